// file: core/tapc_pkg.sv
// Constants and types for the boundary-scan test access port.
// Assumes one fast system clock that oversamples the scan pins.
package tapc_pkg;
    localparam int  CELL_NUM  = 4;
    localparam int  BSR_LEN   = 3 * CELL_NUM;
    localparam int  IR_LEN    = 4;
    localparam int  ID_LEN    = 32;
    localparam int  SYNC_LEN  = 3;
    localparam int  FIFO_W    = BSR_LEN;
    localparam int  FIFO_D    = 16;
    localparam int  TLR_TMS_N = 5;
    // Bit positions of one cell inside the boundary register
    localparam int  CELL_IN   = 0;
    localparam int  CELL_OE   = 1;
    localparam int  CELL_OUT  = 2;
    // Opcodes
    localparam logic [IR_LEN-1:0] OP_EXTEST   = 4'h0;
    localparam logic [IR_LEN-1:0] OP_SAMPLE   = 4'h1;
    localparam logic [IR_LEN-1:0] OP_IDCODE   = 4'h2;
    localparam logic [IR_LEN-1:0] OP_USERCODE = 4'h3;
    localparam logic [IR_LEN-1:0] OP_CLAMP    = 4'h4;
    localparam logic [IR_LEN-1:0] OP_HIGHZ    = 4'h5;
    localparam logic [IR_LEN-1:0] OP_BYPASS   = 4'hf;
    localparam logic [IR_LEN-1:0] IR_RST_VAL  = OP_IDCODE;
    localparam logic [1:0]        IR_CAP_VAL  = 2'h1;
    localparam logic [2:0]        TMS_CNT_RST = 3'h0;

    typedef enum logic [15:0] {
        TAPC_TLR   = 16'h0001,
        TAPC_RTI   = 16'h0002,
        TAPC_SELDR = 16'h0004,
        TAPC_CAPDR = 16'h0008,
        TAPC_SHDR  = 16'h0010,
        TAPC_EX1DR = 16'h0020,
        TAPC_PSDR  = 16'h0040,
        TAPC_EX2DR = 16'h0080,
        TAPC_UPDR  = 16'h0100,
        TAPC_SELIR = 16'h0200,
        TAPC_CAPIR = 16'h0400,
        TAPC_SHIR  = 16'h0800,
        TAPC_EX1IR = 16'h1000,
        TAPC_PSIR  = 16'h2000,
        TAPC_EX2IR = 16'h4000,
        TAPC_UPIR  = 16'h8000
    } tapc_state_t;
endpackage

// file: core/tapc_fifo.sv
// Snapshot buffer: flip-flop FIFO with valid/ready on both sides.
// Assumes a single clock domain; clk_en freezes all state.
`timescale 1ns/100ps
module tapc_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             clk_en,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_r;
    logic [AW-1:0]    rd_r;
    logic [AW:0]      cnt_r;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign push      = in_valid && in_ready && clk_en;
    assign pop       = out_valid && out_ready && clk_en;
    assign out_data  = mem_r[rd_r];

    // Storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wr_r] <= in_data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule // tapc_fifo

// file: core/tapc_top.sv
// Boundary-scan test access port with boundary cells and snapshot buffer.
// Assumes scan pins arrive asynchronously and are oversampled by clk.
// Contract
// RULE1: Sixteen-state controller steps on TCK rise by TMS
// RULE2: Reset state: scan idle, IR loads IDCODE
// RULE3: Five TMS-high clocks or TRST low reset
// RULE4: Stay in reset while TMS high or TRST
// RULE5: Tester reaches Shift-IR using TMS 01100
// RULE6: TDO drives only in shift, switched on fall
// RULE7: Shift-IR shifts IR out, holds while TMS low
// RULE8: IR bits sampled on rise; last with TMS
// RULE9: Capture pin, core enable, core value per cell
// RULE10: Sample/preload leaves live core signals on pins
// RULE11: Shift-DR chains boundary cells from TDI to TDO
// RULE12: Update copies capture cells into update cells
// RULE13: Shift-DR holds on TMS low, two highs update
// RULE14: Extest drives pins and core from update cells
// RULE15: Update enable bit one tri-states that pin
// RULE16: All-ones opcode selects one-bit bypass
// RULE17: Bypass bit in on rise, out on fall
// RULE18: Idcode loads and shifts 32-bit identity
// RULE19: Usercode shifts the user code register out
// RULE20: Clamp uses bypass, pins from update cells
// RULE21: Highz uses bypass, all pins tri-stated
// RULE22: Bus hold or pull-up overrides forced high-Z
// RULE23: Other transitions follow standard controller graph
`timescale 1ns/100ps
module tapc_top #(
    parameter logic [31:0] ID_VALUE   = 32'h1234_5671, // Arbitrary value
    parameter logic [31:0] USER_VALUE = 32'h0000_0000
) (
    // Clock and reset
    input  wire logic                             clk,
    input  wire logic                             reset_n,
    input  wire logic                             clk_en,
    // Scan pins
    input  wire logic                             tck,
    input  wire logic                             tms,
    input  wire logic                             tdi,
    input  wire logic                             trst_n,
    output logic                                  tdo_out,
    output logic                                  tdo_oe,
    // Pads
    input  wire logic [tapc_pkg::CELL_NUM-1:0]    pad_in,
    output logic      [tapc_pkg::CELL_NUM-1:0]    pad_out,
    output logic      [tapc_pkg::CELL_NUM-1:0]    pad_oe,
    input  wire logic [tapc_pkg::CELL_NUM-1:0]    pad_hold_en,
    output logic      [tapc_pkg::CELL_NUM-1:0]    pad_keeper_on,
    // Core side
    input  wire logic [tapc_pkg::CELL_NUM-1:0]    core_output_value,
    input  wire logic [tapc_pkg::CELL_NUM-1:0]    core_output_enable,
    output logic      [tapc_pkg::CELL_NUM-1:0]    core_input_drive,
    // Snapshot stream
    output logic                                  snap_valid,
    input  wire logic                             snap_ready,
    output logic      [tapc_pkg::FIFO_W-1:0]      snap_data,
    output logic                                  snap_room,
    // Status
    output logic                                  test_reset_state,
    output logic                                  dr_capture_shift_clock
);
    import tapc_pkg::*;

    localparam int SYN_W = 4 + CELL_NUM;

    logic [SYN_W-1:0]   syn1_r;
    logic [SYN_W-1:0]   syn2_r;
    logic [SYN_W-1:0]   syn3_r;
    logic               tck_rise;
    logic               tck_fall;
    logic               tms_s;
    logic               tdi_s;
    logic               trst_s;
    logic [CELL_NUM-1:0] pin_s;
    tapc_state_t        state_r;
    tapc_state_t        state_nxt;
    logic [IR_LEN-1:0]  ir_r;
    logic [IR_LEN-1:0]  ir_sh_r;
    logic [BSR_LEN-1:0] bsr_r;
    logic [BSR_LEN-1:0] upd_r;
    logic [ID_LEN-1:0]  id_sh_r;
    logic               byp_r;
    logic               tdo_nxt;
    logic               sel_bsr;
    logic               sel_id;
    logic               test_drive;
    logic               snap_push;
    logic [2:0]         tms_cnt_r;

    // Next controller state from TMS
    function automatic tapc_state_t step(input tapc_state_t s, input logic m);
        case (s)
            TAPC_TLR:   step = m ? TAPC_TLR   : TAPC_RTI;
            TAPC_RTI:   step = m ? TAPC_SELDR : TAPC_RTI;
            TAPC_SELDR: step = m ? TAPC_SELIR : TAPC_CAPDR;
            TAPC_CAPDR: step = m ? TAPC_EX1DR : TAPC_SHDR;
            TAPC_SHDR:  step = m ? TAPC_EX1DR : TAPC_SHDR;
            TAPC_EX1DR: step = m ? TAPC_UPDR  : TAPC_PSDR;
            TAPC_PSDR:  step = m ? TAPC_EX2DR : TAPC_PSDR;
            TAPC_EX2DR: step = m ? TAPC_UPDR  : TAPC_SHDR;
            TAPC_UPDR:  step = m ? TAPC_SELDR : TAPC_RTI;
            TAPC_SELIR: step = m ? TAPC_TLR   : TAPC_CAPIR;
            TAPC_CAPIR: step = m ? TAPC_EX1IR : TAPC_SHIR;
            TAPC_SHIR:  step = m ? TAPC_EX1IR : TAPC_SHIR;
            TAPC_EX1IR: step = m ? TAPC_UPIR  : TAPC_PSIR;
            TAPC_PSIR:  step = m ? TAPC_EX2IR : TAPC_PSIR;
            TAPC_EX2IR: step = m ? TAPC_UPIR  : TAPC_SHIR;
            TAPC_UPIR:  step = m ? TAPC_SELDR : TAPC_RTI;
            default:    step = TAPC_TLR;
        endcase
    endfunction

    // Opcodes that put the single bypass bit in the chain
    function automatic logic is_bypass(input logic [IR_LEN-1:0] op);
        is_bypass = !(op == OP_EXTEST || op == OP_SAMPLE
                      || op == OP_IDCODE || op == OP_USERCODE);
    endfunction

    // Three-stage pin synchroniser
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            syn1_r <= '0;
            syn2_r <= '0;
            syn3_r <= '0;
        end else if (clk_en) begin
            syn1_r <= {trst_n, tdi, tms, tck, pad_in};
            syn2_r <= syn1_r;
            syn3_r <= syn2_r;
        end
    end

    assign tck_rise = clk_en && syn2_r[CELL_NUM] && !syn3_r[CELL_NUM];
    assign tck_fall = clk_en && !syn2_r[CELL_NUM] && syn3_r[CELL_NUM];
    assign tms_s    = syn3_r[CELL_NUM+1];
    assign tdi_s    = syn3_r[CELL_NUM+2];
    assign trst_s   = syn3_r[CELL_NUM+3];
    assign pin_s    = syn3_r[CELL_NUM-1:0];

    assign state_nxt = step(state_r, tms_s); // RULE23

    // Controller
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= TAPC_TLR; // RULE2
        end else if (clk_en && !trst_s) begin
            state_r <= TAPC_TLR; // RULE3 RULE4
        end else if (tck_rise) begin
            state_r <= state_nxt; // RULE1 RULE13
        end
    end

    // Instruction register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ir_r    <= IR_RST_VAL;
            ir_sh_r <= '0;
        end else if (clk_en) begin
            if (state_r == TAPC_TLR) begin
                ir_r <= IR_RST_VAL; // RULE2
            end else if (tck_fall && state_r == TAPC_UPIR) begin
                ir_r <= ir_sh_r;
            end
            if (tck_rise && state_r == TAPC_CAPIR) begin
                ir_sh_r <= ir_r; // RULE7
            end else if (tck_rise && state_r == TAPC_SHIR) begin
                ir_sh_r <= {tdi_s, ir_sh_r[IR_LEN-1:1]}; // RULE8
            end
        end
    end

    assign sel_bsr = (ir_r == OP_EXTEST) || (ir_r == OP_SAMPLE);
    assign sel_id  = (ir_r == OP_IDCODE) || (ir_r == OP_USERCODE);

    // Data registers: capture and shift on TCK rise
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bsr_r   <= '0;
            id_sh_r <= '0;
            byp_r   <= 1'b0;
        end else if (tck_rise && state_r == TAPC_CAPDR) begin
            for (int i = 0; i < CELL_NUM; i++) begin
                bsr_r[3*i+CELL_IN]  <= pin_s[i]; // RULE9
                bsr_r[3*i+CELL_OE]  <= core_output_enable[i];
                bsr_r[3*i+CELL_OUT] <= core_output_value[i];
            end
            id_sh_r <= (ir_r == OP_USERCODE) ? USER_VALUE : ID_VALUE; // RULE18 RULE19
            byp_r   <= 1'b0;
        end else if (tck_rise && state_r == TAPC_SHDR) begin
            if (sel_bsr) begin
                bsr_r <= {tdi_s, bsr_r[BSR_LEN-1:1]}; // RULE11
            end
            if (sel_id) begin
                id_sh_r <= {tdi_s, id_sh_r[ID_LEN-1:1]}; // RULE18 RULE19
            end
            if (is_bypass(ir_r)) begin
                byp_r <= tdi_s; // RULE16 RULE17
            end
        end
    end

    // Update cells load on TCK fall in Update-DR
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            upd_r <= '0;
        end else if (tck_fall && state_r == TAPC_UPDR && sel_bsr) begin
            upd_r <= bsr_r; // RULE12
        end
    end

    // TDO source and driver, switched on TCK fall
    always_comb begin
        tdo_nxt = byp_r;
        if (state_r == TAPC_SHIR) begin
            tdo_nxt = ir_sh_r[0]; // RULE7
        end else if (sel_bsr) begin
            tdo_nxt = bsr_r[0]; // RULE11
        end else if (sel_id) begin
            tdo_nxt = id_sh_r[0];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tdo_out <= 1'b0;
            tdo_oe  <= 1'b0;
        end else if (tck_fall) begin
            tdo_out <= tdo_nxt; // RULE17
            tdo_oe  <= (state_r == TAPC_SHIR) || (state_r == TAPC_SHDR); // RULE6
        end else if (clk_en && !trst_s) begin
            tdo_oe  <= 1'b0; // RULE6
        end
    end

    // Pin and core muxes per cell
    assign test_drive = (ir_r == OP_EXTEST) || (ir_r == OP_CLAMP);

    generate
        for (genvar g = 0; g < CELL_NUM; g++) begin : g_cell
            logic forced_z;
            always_comb begin
                forced_z = 1'b0;
                if (ir_r == OP_HIGHZ) begin
                    forced_z = 1'b1; // RULE21
                end else if (test_drive) begin
                    forced_z = upd_r[3*g+CELL_OE]; // RULE15 RULE20
                end
            end
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    pad_out[g]          <= 1'b0;
                    pad_oe[g]           <= 1'b0;
                    pad_keeper_on[g]    <= 1'b0;
                    core_input_drive[g] <= 1'b0;
                end else if (clk_en) begin
                    if (test_drive || ir_r == OP_HIGHZ) begin
                        pad_out[g] <= upd_r[3*g+CELL_OUT]; // RULE14 RULE20
                        pad_oe[g]  <= !forced_z; // RULE15
                    end else begin
                        pad_out[g] <= core_output_value[g]; // RULE10
                        pad_oe[g]  <= core_output_enable[g];
                    end
                    pad_keeper_on[g] <= forced_z && pad_hold_en[g]
                                        && (test_drive || ir_r == OP_HIGHZ); // RULE22
                    core_input_drive[g] <= (ir_r == OP_EXTEST) ?
                                           upd_r[3*g+CELL_IN] : pin_s[g]; // RULE14
                end
            end
        end
    endgenerate

    // Snapshot of each capture under EXTEST or SAMPLE, queued toward the core while the buffer has room
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            snap_push <= 1'b0;
        end else if (clk_en) begin
            snap_push <= tck_rise && state_r == TAPC_CAPDR && sel_bsr;
        end
    end

    tapc_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_D)
    ) u_snap_fifo (
        .clk       (clk),
        .reset_n   (reset_n),
        .clk_en    (clk_en),
        .in_valid  (snap_push),
        .in_ready  (snap_room),
        .in_data   (bsr_r),
        .out_valid (snap_valid),
        .out_ready (snap_ready),
        .out_data  (snap_data)
    );

    assign test_reset_state       = (state_r == TAPC_TLR);
    assign dr_capture_shift_clock = tck_rise &&
                                    (state_r == TAPC_CAPDR || state_r == TAPC_SHDR);

    // Count of consecutive TCK rises with TMS high
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tms_cnt_r <= TMS_CNT_RST;
        end else if (tck_rise) begin
            if (!tms_s) begin
                tms_cnt_r <= TMS_CNT_RST;
            end else if (tms_cnt_r != 3'(TLR_TMS_N)) begin
                tms_cnt_r <= tms_cnt_r + 3'h1;
            end
        end
    end

    // Checks
    five_tms_tlr_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE3
        tms_cnt_r == 3'(TLR_TMS_N) |-> state_r == TAPC_TLR)
        else $error("Five TMS-high clocks did not reach reset state");
    trst_tlr_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE4
        clk_en && !trst_s |=> state_r == TAPC_TLR)
        else $error("TRST low did not hold reset state");
    tdo_on_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE6
        tck_fall && (state_r == TAPC_SHIR || state_r == TAPC_SHDR) |=> tdo_oe)
        else $error("TDO not driven in shift state");
    tdo_off_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE6
        !tdo_oe && !tck_fall |=> !tdo_oe)
        else $error("TDO enabled away from a falling edge");
    shift_ir_hold_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE7
        tck_rise && trst_s && state_r == TAPC_SHIR && !tms_s |=> state_r == TAPC_SHIR)
        else $error("Left Shift-IR with TMS low");
    bypass_path_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE17
        tck_rise && state_r == TAPC_SHDR && ir_r == OP_BYPASS |=> byp_r == $past(tdi_s))
        else $error("Bypass bit did not take TDI");
    sample_live_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE10
        clk_en && ir_r == OP_SAMPLE && $stable(ir_r) |=> pad_out == $past(core_output_value))
        else $error("Sample disturbed pin output");
    highz_pins_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE21
        clk_en && ir_r == OP_HIGHZ ##1 ir_r == OP_HIGHZ |-> pad_oe == '0)
        else $error("Pin driven under HIGHZ");
    update_copy_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE12
        tck_fall && state_r == TAPC_UPDR && sel_bsr |=> upd_r == $past(bsr_r))
        else $error("Update cells did not take capture cells");

    reach_shift_ir_c: cover property (@(posedge clk) disable iff (!reset_n)
        state_r == TAPC_SHIR);
    extest_update_c: cover property (@(posedge clk) disable iff (!reset_n)
        tck_fall && state_r == TAPC_UPDR && ir_r == OP_EXTEST);
    snap_full_c: cover property (@(posedge clk) disable iff (!reset_n) !snap_room);
endmodule // tapc_top

// file: dv/tapc_tester.sv
// Board tester model: drives TCK, TMS, TDI and TRST, reads TDO.
// Assumes a 32 ns TCK unrelated to clk, idle low between frames.
`timescale 1ns/100ps
module tapc_tester (
    // Scan pins
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    output logic      trst_n,
    input  wire logic tdo_out,
    input  wire logic tdo_oe
);
    logic tdo_s;
    logic oe_s;

    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        trst_n = 1'b1;
    end

    // One TCK pulse; TDO read in the high phase, before the fall moves it
    task automatic step(input logic m, input logic d);
        tms = m;
        tdi = d;
        #14;
        tck = 1'b1;
        #8;
        tdo_s = tdo_out;
        oe_s = tdo_oe;
        #8;
        tck = 1'b0;
        #2;
    endtask

    task automatic set_trst(input logic v);
        trst_n = v;
        #40;
    endtask

    // Full IR or DR scan from Run-Test/Idle or reset, back to Run-Test/Idle
    task automatic scan(input logic ir, input logic ft, input int n, input logic [31:0] din,
                        output logic [31:0] dout, output logic oe_ok);
        #1.7;
        if (ft) step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        if (ir) step(1'b1, 1'b0);
        step(1'b0, 1'b0);
        step(1'b0, 1'b0);
        oe_ok = ~oe_s;
        dout = 32'h0;
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i]);
            dout[i] = tdo_s;
            oe_ok = oe_ok & oe_s;
        end
        step(1'b1, 1'b0);
        oe_ok = oe_ok & ~oe_s;
        step(1'b0, 1'b0);
    endtask
endmodule // tapc_tester

// file: dv/test_boundary_scan_tap_controller.sv
// Self-checking bench for the scan port, pad cells and snapshot buffer.
// Assumes tapc_tester drives the scan pins.
`timescale 1ns/100ps
module test_boundary_scan_tap_controller;
    import tapc_pkg::*;
    localparam logic [31:0] ID_EXP   = 32'h5a3c_9e17; // Arbitrary value
    localparam logic [31:0] USER_EXP = 32'h0c4f_21b6;
    localparam logic [11:0] PRE      = 12'h5b3;
    localparam logic [11:0] NXT      = 12'h3a6;
    logic              clk, clk_en, reset_n, tck, tms, tdi, trst_n, tdo_out, tdo_oe;
    logic [3:0]        pad_in, pad_out, pad_oe, pad_hold_en, pad_keeper_on;
    logic [3:0]        core_output_value, core_output_enable, core_input_drive;
    logic              snap_valid, snap_ready, snap_room, test_reset_state, dr_clk;
    logic [11:0]       snap_data;
    logic [31:0]       dout;
    logic              oe_ok;
    logic [3:0]        prev_op;
    int                failures, compares;
    int                dr_pulses = 0;

    tapc_top #(.ID_VALUE(ID_EXP), .USER_VALUE(USER_EXP)) i_tapc_top (
        .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .tck(tck), .tms(tms), .tdi(tdi),
        .trst_n(trst_n), .tdo_out(tdo_out), .tdo_oe(tdo_oe), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe), .pad_hold_en(pad_hold_en),
        .pad_keeper_on(pad_keeper_on), .core_output_value(core_output_value),
        .core_output_enable(core_output_enable), .core_input_drive(core_input_drive),
        .snap_valid(snap_valid), .snap_ready(snap_ready), .snap_data(snap_data),
        .snap_room(snap_room), .test_reset_state(test_reset_state),
        .dr_capture_shift_clock(dr_clk));
    tapc_tester i_tapc_tester (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
        .tdo_out(tdo_out), .tdo_oe(tdo_oe));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk)
        if (dr_clk) dr_pulses <= dr_pulses + 1;

    task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic close_out();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask

    function automatic logic [11:0] cap_word();
        logic [11:0] w;
        for (int i = 0; i < CELL_NUM; i++) begin
            w[3*i+CELL_IN] = pad_in[i];
            w[3*i+CELL_OE] = core_output_enable[i];
            w[3*i+CELL_OUT] = core_output_value[i];
        end
        return w;
    endfunction

    task automatic dr(input int n, input logic [31:0] din, input logic ft);
        i_tapc_tester.scan(1'b0, ft, n, din, dout, oe_ok);
        settle();
        chk_bit("tdo enable dr", 1'b1, oe_ok);
    endtask

    task automatic load_ir(input logic [3:0] op, input logic ft);
        i_tapc_tester.scan(1'b1, ft, IR_LEN, 32'(op), dout, oe_ok);
        settle();
        chk_val("ir capture", 32'(prev_op), dout);
        chk_bit("tdo enable ir", 1'b1, oe_ok);
        prev_op = op;
    endtask

    task automatic pads_normal();
        chk_val("pad out", 32'(core_output_value), 32'(pad_out));
        chk_val("pad enable", 32'(core_output_enable), 32'(pad_oe));
        chk_val("core drive", 32'(pad_in), 32'(core_input_drive));
    endtask

    // Mode 0 extest, 1 clamp, 2 highz
    task automatic chk_forced(input logic [11:0] u, input int mode);
        logic [3:0] eo, ee, ek, ec;
        for (int i = 0; i < CELL_NUM; i++) begin
            eo[i] = u[3*i+CELL_OUT];
            ee[i] = (mode == 2) ? 1'b0 : ~u[3*i+CELL_OE];
            ek[i] = ((mode == 2) | u[3*i+CELL_OE]) & pad_hold_en[i];
            ec[i] = u[3*i+CELL_IN];
        end
        if (mode != 2) chk_val("forced out", 32'(eo), 32'(pad_out));
        chk_val("forced enable", 32'(ee), 32'(pad_oe));
        chk_val("keeper", 32'(ek), 32'(pad_keeper_on));
        if (mode == 0) chk_val("forced core", 32'(ec), 32'(core_input_drive));
    endtask

    task automatic pop_snap(input logic [11:0] exp);
        chk_bit("snap valid", 1'b1, snap_valid);
        chk_val("snap data", 32'(exp), 32'(snap_data));
        @(posedge clk) snap_ready <= 1'b1;
        @(posedge clk) snap_ready <= 1'b0;
        #1;
    endtask

    task automatic t_reset();
        chk_bit("reset state", 1'b1, test_reset_state);
        chk_bit("tdo idle", 1'b0, tdo_oe);
        pads_normal();
        dr(ID_LEN, 32'h0, 1'b1);
        chk_val("idcode", ID_EXP, dout);
        chk_val("dr clock", 32'(ID_LEN + 1), 32'(dr_pulses));
        chk_bit("reset left", 1'b0, test_reset_state);
        $display("test reset done");
    endtask

    task automatic t_resets();
        i_tapc_tester.step(1'b1, 1'b0);
        repeat (3) i_tapc_tester.step(1'b0, 1'b0);
        i_tapc_tester.set_trst(1'b0);
        settle();
        chk_bit("trst reset", 1'b1, test_reset_state);
        i_tapc_tester.step(1'b0, 1'b0);
        settle();
        chk_bit("trst held", 1'b1, test_reset_state);
        i_tapc_tester.set_trst(1'b1);
        i_tapc_tester.step(1'b0, 1'b0);
        i_tapc_tester.step(1'b1, 1'b0);
        repeat (3) i_tapc_tester.step(1'b0, 1'b0);
        repeat (4) i_tapc_tester.step(1'b1, 1'b0);
        settle();
        chk_bit("four highs", 1'b0, test_reset_state);
        i_tapc_tester.step(1'b1, 1'b0);
        settle();
        chk_bit("five highs", 1'b1, test_reset_state);
        repeat (3) i_tapc_tester.step(1'b1, 1'b0);
        settle();
        chk_bit("tms held", 1'b1, test_reset_state);
        $display("test resets done");
    endtask

    task automatic t_sample();
        @(posedge clk);
        core_output_value <= 4'h6;
        core_output_enable <= 4'hc;
        pad_in <= 4'h9;
        load_ir(OP_SAMPLE, 1'b1);
        dr(2 * BSR_LEN, {8'h0, PRE, 12'hc2e}, 1'b0);
        chk_val("sample capture", 32'(cap_word()), 32'(dout[11:0]));
        chk_val("chain through", 32'hc2e, 32'(dout[23:12]));
        pads_normal();
        pop_snap(cap_word());
        chk_bit("snap empty", 1'b0, snap_valid);
        $display("test sample done");
    endtask

    task automatic t_extest();
        @(posedge clk) pad_hold_en <= 4'h5;
        load_ir(OP_EXTEST, 1'b0);
        chk_forced(PRE, 0);
        dr(BSR_LEN, 32'(NXT), 1'b0);
        chk_val("extest capture", 32'(cap_word()), dout);
        chk_forced(NXT, 0);
        pop_snap(cap_word());
        $display("test extest done");
    endtask

    task automatic t_bypass();
        logic [3:0] ops [4];
        ops = '{OP_CLAMP, OP_HIGHZ, OP_BYPASS, 4'h9};
        for (int k = 0; k < 4; k++) begin
            load_ir(ops[k], 1'b0);
            dr(8, 32'hb4, 1'b0);
            chk_val("bypass out", 32'h34, 32'(dout[7:1]));
            if (ops[k] == OP_CLAMP) chk_forced(NXT, 1);
            if (ops[k] == OP_HIGHZ) chk_forced(NXT, 2);
        end
        load_ir(OP_USERCODE, 1'b0);
        dr(ID_LEN, 32'h0, 1'b0);
        chk_val("usercode", USER_EXP, dout);
        $display("test bypass done");
    endtask

    task automatic t_fifo();
        load_ir(OP_SAMPLE, 1'b0);
        for (int k = 1; k <= FIFO_D + 1; k++) begin
            dr(1, 32'h0, 1'b0);
            if (k >= FIFO_D - 1) chk_bit("snap room", k < FIFO_D, snap_room);
        end
        @(posedge clk) clk_en <= 1'b0;
        @(posedge clk) snap_ready <= 1'b1;
        @(posedge clk) {clk_en, snap_ready} <= 2'b10;
        repeat (FIFO_D) pop_snap(cap_word());
        chk_bit("snap drained", 1'b0, snap_valid);
        $display("test fifo done");
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        $display("watchdog expired");
        close_out();
    end

    initial begin
        reset_n = 1'b0;
        clk_en = 1'b1;
        snap_ready = 1'b0;
        pad_in = 4'h0;
        pad_hold_en = 4'h0;
        core_output_value = 4'h3;
        core_output_enable = 4'ha;
        failures = 0;
        compares = 0;
        prev_op = OP_IDCODE;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        settle();
        t_reset();
        t_resets();
        t_sample();
        t_extest();
        t_bypass();
        t_fifo();
        close_out();
    end
endmodule // test_boundary_scan_tap_controller
